//--- switch_port_policy_control.sv
// Port policy, rate metering, forwarding decision and device control
//
// Functional notes
// R1 - Manual copper port runs forced 10/100/1000
// R2 - Forced gigabit half duplex is rejected
// R3 - Forced speed/duplex applied only in manual
// R4 - Separate ingress and egress caps per port
// R5 - Egress excess raises pause, never drops
// R6 - Ingress excess dropped, no flow control
// R7 - Limit is granularity times multiplier n
// R8 - Multiplier n accepted only 1 to 100
// R9 - Learning fills table, forwards to owner
// R10 - Learning off: table empty, flood others
// R11 - Pause enable flips on each toggle
// R12 - Scheduling weighted or strict priority
// R13 - OAM PDU limit kept within 60..1518
// R14 - Remote reset obeyed only when accepted
// R15 - Send reset request to fiber 1 or 2
// R16 - Eight-entry map from CoS to priority
// R17 - Per-fiber link fault pass-through enable
// R18 - Load defaults restores and stores settings
// R19 - Confirmed reboot gives warm restart
// R20 - Inactive port passes nothing, link down
// R21 - Port settings apply only on save; the code applies ingress and egress rate caps as soon as they are written
// R22 - Credit meter per direction, unlimited bypass
`timescale 1ns/1ps
module switch_port_policy_control
	import port_policy_pkg::*;
#(
	parameter int REFILL = REFILL_CYCLES
) (
	// Clock, reset, enable
	input  wire logic                  ref_clk,
	input  wire logic                  srst,
	input  wire logic                  ce,
	// AXI4-Lite slave
	input  wire logic [AXI_AW-1:0]     awaddr,
	input  wire logic                  awvalid,
	output logic                       awready,
	input  wire logic [31:0]           wdata,
	input  wire logic [3:0]            wstrb,
	input  wire logic                  wvalid,
	output logic                       wready,
	output logic [1:0]                 bresp,
	output logic                       bvalid,
	input  wire logic                  bready,
	input  wire logic [AXI_AW-1:0]     araddr,
	input  wire logic                  arvalid,
	output logic                       arready,
	output logic [31:0]                rdata,
	output logic [1:0]                 rresp,
	output logic                       rvalid,
	input  wire logic                  rready,
	// Rate metering events
	input  wire logic [3:0]            ing_valid,
	input  wire logic [3:0][LEN_W-1:0] ing_len,
	output logic [3:0]                 ing_pass,
	output logic [3:0]                 ing_drop,
	input  wire logic [3:0]            eg_valid,
	input  wire logic [3:0][LEN_W-1:0] eg_len,
	output logic [3:0]                 pause_req,
	// Forwarding decision
	input  wire logic                  fwd_valid,
	input  wire fwd_req_t              fwd_req,
	output logic                       fwd_done,
	output fwd_res_t                   fwd_res,
	// Port control
	output logic [3:0]                 port_link_en,
	output logic [3:0]                 port_forced,
	output logic [3:0][1:0]            port_speed,
	output logic [3:0]                 port_full,
	// Device control
	output logic                       learn_en,
	output logic                       pause_en,
	output logic                       qos_strict,
	output logic [1:0]                 link_fault_passthrough,
	output logic [10:0]                oam_max_len,
	input  wire logic                  remote_rst_cmd,
	output logic [1:0]                 remote_rst_req,
	output logic                       warm_restart,
	output logic                       nvm_store
);

	////////////////////////////////////////////////////////////////////////
	// State
	logic [5:0]      dev_q;
	logic [10:0]     oam_q;
	logic [15:0]     cos_q;
	port_cfg_t       stage [NPORT];
	port_cfg_t       cur   [NPORT];
	rate_cfg_t       ing_cfg [NPORT];
	rate_cfg_t       eg_cfg  [NPORT];
	logic            aw_rdy;
	logic [17:0]     tick_cnt;
	logic [47:0]     tab_mac  [TAB_DEPTH];
	logic [1:0]      tab_port [TAB_DEPTH];
	logic [TAB_DEPTH-1:0] tab_vld;

	// Checks pause in reset and while the clock enable holds state
	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (srst || !ce);

	////////////////////////////////////////////////////////////////////////
	// Register read decode, shared by reads and write merges
	function automatic logic [32:0] reg_val(input logic [7:0] a);
		logic [1:0]  p;
		logic [32:0] v;
		p = a[5:4] - 2'h2;
		v = {1'b0, 32'h0};
		if (a == A_DEV)
			v = {1'b1, 26'h0, dev_q};
		else if (a == A_OAM)
			v = {1'b1, 21'h0, oam_q};
		else if (a == A_COS)
			v = {1'b1, 16'h0, cos_q};
		else if (a == A_CMD)
			v = {1'b1, 32'h0};
		else if (a == A_STAT)
			v = {1'b1, 24'h0, port_link_en, pause_req};
		else if (a >= A_PORT_BASE && a < A_PORT_END && a[1:0] == 2'h0) begin
			case (a[3:2])
				P_CFG:   v = {1'b1, 27'h0, stage[p]};
				P_ING:   v = {1'b1, 23'h0, ing_cfg[p]};
				P_EG:    v = {1'b1, 23'h0, eg_cfg[p]};
				default: v = {1'b1, 27'h0, cur[p]};
			endcase
		end
		return v;
	endfunction : reg_val

	////////////////////////////////////////////////////////////////////////
	// Write decode
	wire        wr_fire = ce & awvalid & awready & wvalid & wready;
	wire [7:0]  wa      = awaddr;
	logic [32:0] wold;
	logic [32:0] rv;
	// Processes, not wires, so state read inside the decode is tracked
	always_comb wold = reg_val(wa);
	always_comb rv = reg_val(araddr);
	wire [31:0] wmask   = {{8{wstrb[3]}}, {8{wstrb[2]}},
	                       {8{wstrb[1]}}, {8{wstrb[0]}}};
	wire [31:0] wv      = (wold[31:0] & ~wmask) | (wdata & wmask);
	wire [1:0]  wp      = wa[5:4] - 2'h2;
	wire        w_port  = wa >= A_PORT_BASE && wa < A_PORT_END;
	wire port_cfg_t pc  = port_cfg_t'(wv[4:0]);
	wire rate_cfg_t rc  = rate_cfg_t'(wv[8:0]);
	wire        pc_ok   = pc.speed != 2'h3 &&
	                      !(pc.speed == SPD_1000 && !pc.full); // [R2]
	wire        rc_ok   = rc.gran == GR_UNL ||
	                      (rc.n >= N_MIN && rc.n <= N_MAX); // [R8]
	wire        oam_ok  = wv[10:0] >= OAM_MIN && wv[10:0] <= OAM_MAX; // [R13]
	wire        is_cmd  = wr_fire && wa == A_CMD;
	wire        w_cfg   = wr_fire && w_port && wa[3:2] == P_CFG && pc_ok;
	wire        w_ing   = wr_fire && w_port && wa[3:2] == P_ING && rc_ok;
	wire        w_eg    = wr_fire && w_port && wa[3:2] == P_EG && rc_ok;
	wire        save_fire   = is_cmd && wv[CMD_SAVE];
	wire        dflt_fire   = is_cmd && wv[CMD_DFLT];
	wire        toggle_fire = is_cmd && wv[CMD_PAUSE];
	wire        reboot_fire = is_cmd && wv[CMD_REBOOT] &&
	                          wv[CMD_KEY +: 8] == REBOOT_KEY; // [R19]
	wire        w_bad   = !wold[32] ||
	                      (w_port && wa[3:2] == P_CFG && !pc_ok) ||
	                      (w_port && (wa[3:2] == P_ING ||
	                       wa[3:2] == P_EG) && !rc_ok) ||
	                      (wa == A_OAM && !oam_ok);
	wire        restore = srst || dflt_fire;

	////////////////////////////////////////////////////////////////////////
	// AXI4-Lite handshakes
	assign awready = aw_rdy;
	assign wready  = aw_rdy;

	always_ff @(posedge ref_clk) begin
		if (srst) begin
			aw_rdy <= 1'b0;
			bvalid <= 1'b0;
			bresp  <= RESP_OKAY;
		end else if (ce) begin
			aw_rdy <= awvalid & wvalid & ~aw_rdy & ~bvalid;
			if (wr_fire) begin
				bvalid <= 1'b1;
				bresp  <= w_bad ? RESP_SLV : RESP_OKAY;
			end else if (bready)
				bvalid <= 1'b0;
		end
	end

	always_ff @(posedge ref_clk) begin
		if (srst) begin
			arready <= 1'b0;
			rvalid  <= 1'b0;
			rdata   <= 32'h0;
			rresp   <= RESP_OKAY;
		end else if (ce) begin
			arready <= arvalid & ~arready & ~rvalid;
			if (arvalid && arready) begin
				rvalid <= 1'b1;
				rdata  <= rv[31:0];
				rresp  <= rv[32] ? RESP_OKAY : RESP_SLV;
			end else if (rready)
				rvalid <= 1'b0;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Device settings; defaults restore everything and are then stored
	always_ff @(posedge ref_clk) begin
		if (restore) begin // [R18]
			dev_q <= DEV_RST; // [R14]
			oam_q <= OAM_RST;
			cos_q <= COS_RST;
		end else if (ce) begin
			if (wr_fire && wa == A_DEV)
				dev_q <= {wv[5:2], dev_q[DEV_PAUSE], wv[0]}; // [R17] [R12]
			else if (toggle_fire)
				dev_q[DEV_PAUSE] <= ~dev_q[DEV_PAUSE]; // [R11]
			if (wr_fire && wa == A_OAM && oam_ok)
				oam_q <= wv[10:0]; // [R13]
			if (wr_fire && wa == A_COS)
				cos_q <= wv[15:0]; // [R16]
		end
	end

	// Command pulses
	always_ff @(posedge ref_clk) begin
		if (srst) begin
			remote_rst_req <= 2'h0;
			warm_restart   <= 1'b0;
			nvm_store      <= 1'b0;
		end else if (ce) begin
			remote_rst_req <= is_cmd ? wv[CMD_RMT_B:CMD_RMT_A] : 2'h0; // [R15]
			warm_restart   <= reboot_fire ||
			                  (remote_rst_cmd && dev_q[DEV_ACCEPT]); // [R14]
			nvm_store      <= dflt_fire; // [R18]
		end
	end

	assign learn_en               = dev_q[DEV_LEARN];
	assign pause_en               = dev_q[DEV_PAUSE];
	assign qos_strict             = dev_q[DEV_STRICT]; // [R12]
	assign link_fault_passthrough = dev_q[DEV_LFP +: 2]; // [R17]
	assign oam_max_len            = oam_q;

	////////////////////////////////////////////////////////////////////////
	// Refill interval for all meters
	wire tick = tick_cnt == 18'(REFILL - 1);

	always_ff @(posedge ref_clk) begin
		if (srst)
			tick_cnt <= 18'h0;
		else if (ce)
			tick_cnt <= tick ? 18'h0 : tick_cnt + 18'h1;
	end

	// Bytes granted per interval
	function automatic logic signed [CW-1:0] fill(input rate_cfg_t r);
		logic [CW-1:0] g;
		case (r.gran)
			GR_64K:  g = CW'(B_64K);
			GR_1M:   g = CW'(B_1M);
			GR_10M:  g = CW'(B_10M);
			default: g = CW'(0);
		endcase
		return $signed(g * CW'(r.n)); // [R7]
	endfunction : fill

	////////////////////////////////////////////////////////////////////////
	// Per-port settings and meters
	for (genvar p = 0; p < NPORT; p++) begin : g_port
		logic signed [CW-1:0] ic;
		logic signed [CW-1:0] ec;
		wire logic [1:0]      pi = 2'(p);
		wire signed [CW-1:0]  ifl = fill(ing_cfg[p]);
		wire signed [CW-1:0]  efl = fill(eg_cfg[p]);
		wire signed [CW-1:0]  icap = ifl + CW'(MAX_FRAME);
		wire signed [CW-1:0]  ecap = efl + CW'(MAX_FRAME);
		wire signed [CW-1:0]  ilen = $signed(CW'(ing_len[p]));
		wire signed [CW-1:0]  elen = $signed(CW'(eg_len[p]));
		wire signed [CW-1:0]  iadd = tick ? ic + ifl : ic;
		wire signed [CW-1:0]  eadd = tick ? ec + efl : ec;
		wire                  iunl = ing_cfg[p].gran == GR_UNL;
		wire                  eunl = eg_cfg[p].gran == GR_UNL;
		wire                  ipass = cur[p].active &&
		                              (iunl || iadd >= ilen); // [R6] [R20]
		wire signed [CW-1:0]  isub = iadd - ((ing_valid[p] && ipass) ?
		                              ilen : CW'(0));
		wire signed [CW-1:0]  esub = eadd - (eg_valid[p] ? elen : CW'(0));
		wire signed [CW-1:0]  next_ic = iunl ? CW'(0) :
		                              (isub > icap ? icap : isub);
		// Floor keeps a sender that ignores pause from wrapping the count
		wire signed [CW-1:0]  next_ec = eunl ? CW'(0) :
		                              (esub > ecap ? ecap :
		                              (esub < -ecap ? -ecap : esub));

		always_ff @(posedge ref_clk) begin
			if (restore) begin
				stage[p]   <= port_cfg_t'(PCFG_RST);
				// Auto mode shows no forced speed or duplex
				cur[p]     <= '{full: 1'b0, speed: SPD_10, manual: 1'b0,
				                active: PCFG_RST[0]}; // [R3]
				ing_cfg[p] <= rate_cfg_t'(RATE_RST);
				eg_cfg[p]  <= rate_cfg_t'(RATE_RST);
			end else if (ce) begin
				if (w_cfg && wp == pi)
					stage[p] <= pc;
				if (w_ing && wp == pi)
					ing_cfg[p] <= rc; // [R4]
				if (w_eg && wp == pi)
					eg_cfg[p] <= rc; // [R4]
				if (save_fire) begin // [R21]
					cur[p] <= stage[p].manual ? stage[p] : // [R1]
					          '{full: 1'b0, speed: SPD_10, manual: 1'b0,
					            active: stage[p].active}; // [R3]
				end
			end
		end

		always_ff @(posedge ref_clk) begin
			if (srst) begin
				ic           <= CW'(0);
				ec           <= CW'(0);
				ing_pass[p]  <= 1'b0;
				ing_drop[p]  <= 1'b0;
				pause_req[p] <= 1'b0;
			end else if (ce) begin
				ic           <= next_ic; // [R22]
				ec           <= next_ec; // [R22]
				ing_pass[p]  <= ing_valid[p] & ipass;
				ing_drop[p]  <= ing_valid[p] & ~ipass; // [R6]
				pause_req[p] <= next_ec < CW'(0); // [R5]
			end
		end

		assign port_link_en[p] = cur[p].active; // [R20]
		assign port_forced[p]  = cur[p].manual;
		assign port_speed[p]   = cur[p].speed;
		assign port_full[p]    = cur[p].full;

		chk_half_gig_block: assert property ( // [R2]
			!(cur[p].speed == SPD_1000 && !cur[p].full))
			else $error("gigabit half duplex applied");
		chk_auto_not_forced: assert property ( // [R3]
			!cur[p].manual |-> cur[p].speed == SPD_10 && !cur[p].full)
			else $error("forced settings applied in auto");
		chk_mult_in_range: assert property ( // [R8]
			ing_cfg[p].gran != GR_UNL |->
			ing_cfg[p].n >= N_MIN && ing_cfg[p].n <= N_MAX)
			else $error("multiplier out of range");
		chk_inactive_drops: assert property ( // [R20]
			ing_valid[p] && !cur[p].active |=> ing_drop[p] && !ing_pass[p])
			else $error("inactive port passed traffic");
		chk_unlimited_bypass: assert property ( // [R22]
			ing_valid[p] && iunl && cur[p].active |=> ing_pass[p])
			else $error("unlimited ingress was metered");
		chk_pause_egress_only: assert property ( // [R5]
			pause_req[p] |-> $past(!eunl))
			else $error("pause without egress limit");
	end

	////////////////////////////////////////////////////////////////////////
	// Forwarding decision with address learning
	wire [3:0] di = fwd_req.dst_mac[3:0] ^ fwd_req.dst_mac[11:8];
	wire [3:0] si = fwd_req.src_mac[3:0] ^ fwd_req.src_mac[11:8];
	wire [3:0] src_oh = 4'h1 << fwd_req.src_port;
	wire [3:0] dst_oh = 4'h1 << tab_port[di];
	wire       hit = learn_en && tab_vld[di] && !fwd_req.dst_mac[40] &&
	                 tab_mac[di] == fwd_req.dst_mac; // [R9]
	wire [3:0] flood = port_link_en & ~src_oh; // [R10]
	wire [3:0] next_mask = hit ? (dst_oh & port_link_en & ~src_oh) : flood;
	wire [1:0] next_prio = cos_q[{fwd_req.cos, 1'b0} +: 2]; // [R16]
	wire       learn_wr = learn_en && fwd_valid && !fwd_req.src_mac[40];

	// Entries carry no reset; only the valid bits need one
	always_ff @(posedge ref_clk) begin
		if (ce && learn_wr) begin
			tab_mac[si]  <= fwd_req.src_mac; // [R9]
			tab_port[si] <= fwd_req.src_port;
		end
	end

	always_ff @(posedge ref_clk) begin
		if (srst || (ce && !learn_en))
			tab_vld <= '0; // [R10]
		else if (ce && learn_wr)
			tab_vld[si] <= 1'b1;
	end

	always_ff @(posedge ref_clk) begin
		if (srst) begin
			fwd_done <= 1'b0;
			fwd_res  <= '0;
		end else if (ce) begin
			fwd_done <= fwd_valid;
			if (fwd_valid)
				fwd_res <= '{mask: next_mask, prio: next_prio};
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Checks
	chk_flood_no_learn: assert property ( // [R10]
		fwd_valid && !learn_en |=>
		fwd_res.mask == ($past(port_link_en) & ~$past(src_oh)))
		else $error("flood mask wrong with learning off");
	chk_remote_ignored: assert property ( // [R14]
		remote_rst_cmd && !dev_q[DEV_ACCEPT] && !reboot_fire |=> !warm_restart)
		else $error("remote reset obeyed while refused");
	chk_remote_obeyed: assert property ( // [R14]
		remote_rst_cmd && dev_q[DEV_ACCEPT] |=> warm_restart)
		else $error("accepted remote reset lost");
	chk_pause_toggle: assert property ( // [R11]
		toggle_fire && !dflt_fire && wa == A_CMD |=>
		pause_en != $past(pause_en))
		else $error("pause enable did not flip");
	chk_oam_range: assert property ( // [R13]
		oam_max_len >= OAM_MIN && oam_max_len <= OAM_MAX)
		else $error("oam length out of range");
	chk_link_on_save: assert property ( // [R21]
		$changed(port_link_en) |-> $past(save_fire || dflt_fire))
		else $error("port activation changed without save");
	chk_reboot_key: assert property ( // [R19]
		reboot_fire |=> warm_restart ##1 !warm_restart)
		else $error("confirmed reboot missed");
	chk_remote_req: assert property ( // [R15]
		is_cmd && wv[CMD_RMT_A] |=> remote_rst_req[0])
		else $error("remote request not sent");
	chk_defaults_load: assert property ( // [R18]
		dflt_fire |=> nvm_store && learn_en && oam_max_len == OAM_RST)
		else $error("defaults not restored");

	cov_learn_hit:   cover property (fwd_done && $onehot(fwd_res.mask));
	cov_ing_drop:    cover property (ing_drop[0] && port_link_en[0]);
	cov_pause_rise:  cover property ($rose(pause_req[1]));
	cov_warm_start:  cover property (warm_restart);

endmodule : switch_port_policy_control

//--- port_policy_pkg.sv
// Shared constants and types for the port policy and device control block
package port_policy_pkg;

	////////////////////////////////////////////////////////////////////////
	// Register map (byte addresses)
	localparam int          AXI_AW      = 8;
	localparam logic [7:0]  A_DEV       = 8'h00;
	localparam logic [7:0]  A_OAM       = 8'h04;
	localparam logic [7:0]  A_COS       = 8'h08;
	localparam logic [7:0]  A_CMD       = 8'h0C;
	localparam logic [7:0]  A_STAT      = 8'h10;
	localparam logic [7:0]  A_PORT_BASE = 8'h20;
	localparam logic [7:0]  A_PORT_END  = 8'h60;
	localparam logic [1:0]  P_CFG       = 2'h0;
	localparam logic [1:0]  P_ING       = 2'h1;
	localparam logic [1:0]  P_EG        = 2'h2;
	localparam logic [1:0]  P_STAT      = 2'h3;

	////////////////////////////////////////////////////////////////////////
	// Field positions
	localparam int DEV_LEARN  = 0;
	localparam int DEV_PAUSE  = 1;
	localparam int DEV_STRICT = 2;
	localparam int DEV_ACCEPT = 3;
	localparam int DEV_LFP    = 4;
	localparam int CMD_PAUSE  = 0;
	localparam int CMD_RMT_A  = 1;
	localparam int CMD_RMT_B  = 2;
	localparam int CMD_DFLT   = 3;
	localparam int CMD_SAVE   = 4;
	localparam int CMD_REBOOT = 5;
	localparam int CMD_KEY    = 8;

	////////////////////////////////////////////////////////////////////////
	// Encodings, limits and reset values
	localparam logic [1:0]  SPD_10     = 2'h0;
	localparam logic [1:0]  SPD_100    = 2'h1;
	localparam logic [1:0]  SPD_1000   = 2'h2;
	localparam logic [1:0]  GR_UNL     = 2'h0;
	localparam logic [1:0]  GR_64K     = 2'h1;
	localparam logic [1:0]  GR_1M      = 2'h2;
	localparam logic [1:0]  GR_10M     = 2'h3;
	localparam logic [6:0]  N_MIN      = 7'h01;
	localparam logic [6:0]  N_MAX      = 7'h64;
	localparam logic [10:0] OAM_MIN    = 11'h03C;
	localparam logic [10:0] OAM_MAX    = 11'h5EE;
	localparam logic [10:0] OAM_RST    = 11'h5DC;
	localparam logic [15:0] COS_RST    = 16'hFA50;
	localparam logic [5:0]  DEV_RST    = 6'h01;
	localparam logic [4:0]  PCFG_RST   = 5'h19;
	localparam logic [8:0]  RATE_RST   = 9'h000;
	localparam logic [7:0]  REBOOT_KEY = 8'hA5;
	localparam logic [1:0]  RESP_OKAY  = 2'h0;
	localparam logic [1:0]  RESP_SLV   = 2'h2;

	////////////////////////////////////////////////////////////////////////
	// Timing and metering
	localparam int CLK_MHZ       = 250;
	localparam int REFILL_US     = 1000;
	localparam int REFILL_CYCLES = REFILL_US * CLK_MHZ;
	localparam int BPS_64K       = 64000;
	localparam int BPS_1M        = 1000000;
	localparam int BPS_10M       = 10000000;
	localparam int B_64K = (BPS_64K / 8) * REFILL_US / 1000000;
	localparam int B_1M  = (BPS_1M / 8) * REFILL_US / 1000000;
	localparam int B_10M = (BPS_10M / 8) * REFILL_US / 1000000;
	localparam int CW          = 20;
	localparam int LEN_W       = 11;
	localparam int MAX_FRAME   = 1518;
	localparam int TAB_DEPTH   = 16;
	localparam int NPORT       = 4;

	////////////////////////////////////////////////////////////////////////
	// Types
	typedef struct packed {
		logic       full;
		logic [1:0] speed;
		logic       manual;
		logic       active;
	} port_cfg_t;

	typedef struct packed {
		logic [6:0] n;
		logic [1:0] gran;
	} rate_cfg_t;

	typedef struct packed {
		logic [47:0] src_mac;
		logic [47:0] dst_mac;
		logic [1:0]  src_port;
		logic [2:0]  cos;
	} fwd_req_t;

	typedef struct packed {
		logic [3:0] mask;
		logic [1:0] prio;
	} fwd_res_t;

endpackage : port_policy_pkg

//--- link_partner_model.sv
// Far side model: link partners sending frames and remote converter units
`timescale 1ns/1ps
module link_partner_model
	import port_policy_pkg::*;
(
	// Clock
	input  wire logic             ref_clk,
	// Frames toward the block
	output logic [3:0]            ing_valid,
	output logic [3:0][LEN_W-1:0] ing_len,
	output logic [3:0]            eg_valid,
	output logic [3:0][LEN_W-1:0] eg_len,
	// Remote units
	output logic                  remote_rst_cmd,
	input  wire logic [1:0]       remote_rst_req,
	input  wire logic [1:0]       remote_accept,
	output logic [1:0][7:0]       remote_boots
);
	// Peer OAM limit, must equal the local one
	localparam logic [10:0] PEER_OAM = OAM_RST;

	initial begin
		{ing_valid, ing_len, eg_valid, eg_len} = '0;
		remote_rst_cmd = 1'b0;
		remote_boots = '0;
	end

	// A remote unit restarts only when it accepts resets
	always @(posedge ref_clk)
		for (int i = 0; i < 2; i++)
			if (remote_rst_req[i] && remote_accept[i])
				remote_boots[i] <= remote_boots[i] + 8'h01;

	task frame(input logic eg, input int p, input logic [LEN_W-1:0] len);
		@(posedge ref_clk);
		if (eg) begin
			eg_valid[p] <= 1'b1;
			eg_len[p] <= len;
		end else begin
			ing_valid[p] <= 1'b1;
			ing_len[p] <= len;
		end
		@(posedge ref_clk);
		// Idle lengths flip so a stale value is never mistaken for data
		ing_valid <= '0;
		eg_valid <= '0;
		ing_len[p] <= ~ing_len[p];
		eg_len[p] <= ~eg_len[p];
		#1;
	endtask : frame

	task peer_reset;
		@(posedge ref_clk);
		remote_rst_cmd <= 1'b1;
		@(posedge ref_clk);
		remote_rst_cmd <= 1'b0;
	endtask : peer_reset
endmodule : link_partner_model

//--- tb_switch_port_policy_control.sv
// Self-checking bench for the port policy and device control block
`timescale 1ns/1ps
module tb_switch_port_policy_control
	import port_policy_pkg::*;
;
	logic ref_clk = 0, srst = 1, ce = 1, fwd_valid = 0;
	logic awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
	logic [7:0] awaddr = '0, araddr = '0;
	logic [31:0] wdata = '0, rdata;
	logic [3:0] wstrb = 4'hF;
	logic awready, wready, bvalid, arready, rvalid, fwd_done;
	logic [1:0] bresp, rresp, link_fault_passthrough, remote_rst_req;
	logic [3:0] ing_valid, ing_pass, ing_drop, eg_valid, pause_req;
	logic [3:0][LEN_W-1:0] ing_len, eg_len;
	fwd_req_t fwd_req = '0;
	fwd_res_t fwd_res;
	logic [3:0] port_link_en, port_forced, port_full;
	logic [3:0][1:0] port_speed;
	logic learn_en, pause_en, qos_strict, remote_rst_cmd;
	logic warm_restart, nvm_store;
	logic [10:0] oam_max_len;
	logic [1:0] remote_accept = 2'h1;
	logic [1:0][7:0] remote_boots;
	int failures = 0, n_compared = 0, n_warm = 0, n_nvm = 0, cyc = 0;

	switch_port_policy_control #(.REFILL(50)) u_dut (.*);
	link_partner_model u_link (.*);

	always #2 ref_clk = ~ref_clk;

	////////////////////////////////////////////////////////////////////////
	always @(posedge ref_clk) begin
		cyc <= cyc + 1;
		if (warm_restart === 1'b1) n_warm <= n_warm + 1;
		if (nvm_store === 1'b1) n_nvm <= n_nvm + 1;
		// Whole run needs a few hundred cycles
		if (cyc == 20000) begin
			failures = failures + 1;
			test_done();
		end
	end

	task test_done;
		$display("compared %0d mismatches %0d", n_compared, failures);
		if (failures == 0 && n_compared > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask : test_done

	task check(input logic [31:0] got, input logic [31:0] exp);
		n_compared++;
		if (got !== exp) begin
			failures++;
			$display("[FAIL] %0t got %h expected %h", $time, got, exp);
		end
	endtask : check

	task axi_wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
		@(posedge ref_clk);
		awaddr <= a;
		wdata <= d;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		do @(posedge ref_clk); while (awready !== 1'b1);
		awvalid <= 1'b0;
		wvalid <= 1'b0;
		do @(posedge ref_clk); while (bvalid !== 1'b1);
		bready <= 1'b0;
		check(bresp, er);
	endtask : axi_wr

	task axi_rd(input logic [7:0] a, input logic [31:0] e, input logic [1:0] er);
		@(posedge ref_clk);
		araddr <= a;
		arvalid <= 1'b1;
		rready <= 1'b1;
		do @(posedge ref_clk); while (arready !== 1'b1);
		arvalid <= 1'b0;
		do @(posedge ref_clk); while (rvalid !== 1'b1);
		rready <= 1'b0;
		check(rdata, e);
		check(rresp, er);
	endtask : axi_rd

	task settle;
		repeat (2) @(posedge ref_clk);
		#1;
	endtask : settle

	task fwd(input logic [47:0] s, d, input logic [1:0] p, input int c,
		input logic [5:0] e);
		@(posedge ref_clk);
		fwd_req <= '{src_mac: s, dst_mac: d, src_port: p, cos: 3'(c)};
		fwd_valid <= 1'b1;
		@(posedge ref_clk);
		fwd_valid <= 1'b0;
		#1;
		check({fwd_done, fwd_res}, {1'b1, e});
	endtask : fwd

	function automatic logic [7:0] pa(input int p, input logic [1:0] r);
		return A_PORT_BASE + 8'(p * 16) + {4'h0, r, 2'h0};
	endfunction : pa

	function automatic logic [31:0] rate(input logic [1:0] g, input logic [6:0] n);
		return {23'h0, n, g};
	endfunction : rate

	////////////////////////////////////////////////////////////////////////
	initial begin
		repeat (8) @(posedge ref_clk);
		srst <= 1'b0;
		axi_rd(A_DEV, 32'h1, RESP_OKAY);
		axi_rd(A_COS, 32'hFA50, RESP_OKAY);
		axi_rd(8'h70, 32'h0, RESP_SLV);
		u_link.peer_reset();
		settle();
		check(n_warm, 0);
		axi_wr(A_OAM, OAM_MIN - 11'h1, RESP_SLV);
		axi_wr(A_OAM, OAM_MAX + 11'h1, RESP_SLV);
		axi_wr(A_OAM, OAM_MIN, RESP_OKAY);
		axi_rd(A_OAM, OAM_MIN, RESP_OKAY);
		axi_wr(A_COS, 32'h1B1B, RESP_OKAY);
		for (int c = 0; c < 8; c++)
			fwd(48'h1, 48'h2, 2'h1, c, {4'hD, 2'(16'h1B1B >> (2 * c))});
		fwd(48'h2, 48'h1, 2'h2, 0, 6'h0B);
		axi_wr(A_DEV, 32'h0, RESP_OKAY);
		fwd(48'h2, 48'h1, 2'h2, 0, 6'h2F);
		axi_wr(A_DEV, 32'h1, RESP_OKAY);
		fwd(48'h3, 48'h1, 2'h0, 0, 6'h3B);
		axi_wr(pa(2, P_CFG), 32'h0B, RESP_SLV);
		axi_wr(pa(2, P_CFG), 32'h0F, RESP_SLV);
		axi_wr(pa(2, P_CFG), 32'h03, RESP_OKAY);
		settle();
		check({port_forced[2], port_full[2]}, 2'h0);
		for (int s = 0; s < 3; s++) begin
			axi_wr(pa(2, P_CFG), 32'h13 | 32'(s << 2), RESP_OKAY);
			axi_wr(A_CMD, 32'h10, RESP_OKAY);
			settle();
			check({port_forced[2], port_speed[2], port_full[2]},
			      {1'b1, 2'(s), 1'b1});
		end
		axi_wr(pa(2, P_CFG), 32'h19, RESP_OKAY);
		axi_wr(pa(3, P_CFG), 32'h18, RESP_OKAY);
		axi_wr(A_CMD, 32'h10, RESP_OKAY);
		axi_rd(pa(2, P_STAT), 32'h01, RESP_OKAY);
		check(port_link_en, 4'h7);
		u_link.frame(1'b0, 3, 11'h040);
		check(ing_drop[3], 1'b1);
		fwd(48'h5, 48'h9, 2'h0, 0, 6'h1B);
		axi_wr(pa(0, P_ING), rate(GR_64K, 7'h0), RESP_SLV);
		axi_wr(pa(0, P_ING), rate(GR_64K, N_MAX + 7'h1), RESP_SLV);
		axi_wr(pa(0, P_ING), rate(GR_64K, N_MIN), RESP_OKAY);
		axi_rd(pa(0, P_ING), rate(GR_64K, N_MIN), RESP_OKAY);
		u_link.frame(1'b1, 0, 11'h5EE);
		check(pause_req[0], 1'b0);
		u_link.frame(1'b0, 0, 11'h3E8);
		check({ing_pass[0], ing_drop[0], pause_req[0]}, 3'h2);
		axi_wr(pa(0, P_EG), rate(GR_64K, N_MIN), RESP_OKAY);
		u_link.frame(1'b1, 0, 11'h064);
		check(pause_req[0], 1'b1);
		axi_rd(A_STAT, 32'h71, RESP_OKAY);
		axi_wr(pa(2, P_ING), rate(GR_10M, N_MAX), RESP_OKAY);
		repeat (60) @(posedge ref_clk);
		u_link.frame(1'b0, 2, 11'h5EE);
		check(ing_pass[2], 1'b1);
		u_link.frame(1'b0, 0, 11'h008);
		check(ing_pass[0], 1'b1);
		u_link.frame(1'b0, 1, 11'h5EE);
		check(ing_pass[1], 1'b1);
		axi_wr(A_CMD, 32'h1, RESP_OKAY);
		axi_wr(A_DEV, 32'h2D, RESP_OKAY);
		axi_rd(A_DEV, 32'h2F, RESP_OKAY);
		check({pause_en, qos_strict, link_fault_passthrough}, 4'hE);
		axi_wr(A_CMD, 32'h1, RESP_OKAY);
		u_link.peer_reset();
		settle();
		check({pause_en, 4'(n_warm)}, 5'h01);
		axi_wr(A_CMD, 32'h2, RESP_OKAY);
		axi_wr(A_CMD, 32'h4, RESP_OKAY);
		axi_wr(A_CMD, 32'hA520, RESP_OKAY);
		settle();
		check({remote_boots, 4'(n_warm)}, 20'h00012);
		axi_wr(A_CMD, 32'h8, RESP_OKAY);
		settle();
		check({4'(n_nvm), learn_en, pause_en, port_link_en}, 10'h06F);
		check(oam_max_len, u_link.PEER_OAM);
		axi_rd(A_COS, 32'hFA50, RESP_OKAY);
		test_done();
	end
endmodule : tb_switch_port_policy_control
